// File: rtl/pmmc_pkg.sv
package pmmc_pkg;
    localparam int unsigned PMMC_SW = 24;
    localparam int unsigned PMMC_NPH = 3;
    localparam int unsigned PMMC_HCW = 16;

    // register byte addresses
    localparam logic [7:0] ADDR_MEAS_CFG = 8'h14;
    localparam logic [7:0] ADDR_HALF_CYC = 8'h18;
    localparam logic [7:0] ADDR_VLVL = 8'h1c;
    localparam logic [7:0] ADDR_ILVL = 8'h20;
    localparam logic [7:0] ADDR_VOLTAGE_PEAK_VALUE = 8'h24;
    localparam logic [7:0] ADDR_CURRENT_PEAK_VALUE = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2c;
    localparam logic [7:0] ADDR_MASK = 8'h30;

    // measurement_config fields
    localparam int unsigned FSEL_LSB = 0;
    localparam int unsigned PKEN_LSB = 2;
    localparam int unsigned PKIRQ_LSB = 5;

    // reset values
    localparam logic [7:0] MEAS_CFG_RST = 8'hfc;
    localparam logic [15:0] HALF_CYC_RST = 16'h0064;
    localparam logic [23:0] LVL_RST = 24'hffffff;
    localparam logic [2:0] MASK_RST = 3'h0;

    // status / mask bit positions
    localparam int unsigned ST_VPK = 0;
    localparam int unsigned ST_IPK = 1;
    localparam int unsigned ST_INTV = 2;

    typedef enum logic [1:0] {
        FSEL_A = 2'b00,
        FSEL_B = 2'b01,
        FSEL_C = 2'b10,
        FSEL_RSVD = 2'b11
    } pmmc_fsel_e;

    typedef enum logic [3:0] {
        RS_CFG = 4'h0,
        RS_HCYC = 4'h1,
        RS_VLVL = 4'h2,
        RS_ILVL = 4'h3,
        RS_VPK = 4'h4,
        RS_IPK = 4'h5,
        RS_STAT = 4'h6,
        RS_MASK = 4'h7,
        RS_NONE = 4'hf
    } pmmc_rsel_e;

    function automatic logic [23:0] pmmc_abs(input logic [23:0] s);
        return s[23] ? (~s + 24'h000001) : s;
    endfunction

    function automatic pmmc_rsel_e pmmc_decode(input logic [7:0] a);
        unique case (a)
            ADDR_MEAS_CFG: return RS_CFG;
            ADDR_HALF_CYC: return RS_HCYC;
            ADDR_VLVL: return RS_VLVL;
            ADDR_ILVL: return RS_ILVL;
            ADDR_VOLTAGE_PEAK_VALUE: return RS_VPK;
            ADDR_CURRENT_PEAK_VALUE: return RS_IPK;
            ADDR_STATUS: return RS_STAT;
            ADDR_MASK: return RS_MASK;
            default: return RS_NONE;
        endcase
    endfunction
endpackage

// File: rtl/pmmc_peak_if.sv
`timescale 1ns/1ps
interface pmmc_peak_if;
    import pmmc_pkg::*;
    logic sample_valid;
    logic [2:0][23:0] v_mag;
    logic [2:0][23:0] i_mag;
    logic [2:0] peak_en;
    logic [2:0] irq_en;
    logic [23:0] v_level;
    logic [23:0] i_level;
    logic interval_end;

    modport src (output sample_valid, v_mag, i_mag, peak_en, irq_en, v_level, i_level, interval_end);
    modport sink (input sample_valid, v_mag, i_mag, peak_en, irq_en, v_level, i_level, interval_end);
endinterface

// File: rtl/pmmc_peak_tracker.sv
`timescale 1ns/1ps
module pmmc_peak_tracker
    import pmmc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // samples and enables
    pmmc_peak_if.sink pk,
    // committed peaks
    output logic [23:0] voltage_peak_value_q,
    output logic [23:0] current_peak_value_q
);
    logic [23:0] vrun_q, vrun_d, irun_q, irun_d, voltage_peak_value_d, current_peak_value_d;
    logic [23:0] vmax, imax;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        vmax = vrun_q;
        imax = irun_q;
        for (int p = 0; p < 3; p++) begin
            if (pk.sample_valid && pk.peak_en[p] && pk.v_mag[p] > vmax) begin
                vmax = pk.v_mag[p];
            end
            if (pk.sample_valid && pk.peak_en[p] && pk.i_mag[p] > imax) begin
                imax = pk.i_mag[p];
            end
        end
        vrun_d = vmax;
        irun_d = imax;
        voltage_peak_value_d = voltage_peak_value_q;
        current_peak_value_d = current_peak_value_q;
        if (pk.interval_end) begin
            voltage_peak_value_d = vrun_q;
            current_peak_value_d = irun_q;
            vrun_d = 24'h000000;
            irun_d = 24'h000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vrun_q <= 24'h000000;
            irun_q <= 24'h000000;
            voltage_peak_value_q <= 24'h000000;
            current_peak_value_q <= 24'h000000;
        end else begin
            vrun_q <= vrun_d;
            irun_q <= irun_d;
            voltage_peak_value_q <= voltage_peak_value_d;
            current_peak_value_q <= current_peak_value_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    peak_commit_a: assert property (pk.interval_end |=> voltage_peak_value_q == $past(vrun_q) && current_peak_value_q == $past(irun_q))
        else $error("peak registers not loaded at interval end");
    run_grows_a: assert property (!pk.interval_end && pk.sample_valid && pk.peak_en[0] |=> vrun_q >= $past(pk.v_mag[0]))
        else $error("running voltage peak below enabled sample");
    disabled_ignored_a: assert property (!pk.interval_end && pk.peak_en == 3'b000 |=> irun_q == $past(irun_q))
        else $error("running peak changed with no phase enabled");
endmodule

// File: rtl/pmmc_thresh_mon.sv
`timescale 1ns/1ps
module pmmc_thresh_mon
    import pmmc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // samples, enables and levels
    pmmc_peak_if.sink pk,
    // one-cycle level crossings
    output logic v_hit_q,
    output logic i_hit_q
);
    logic v_hit_d, i_hit_d;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        v_hit_d = 1'b0;
        i_hit_d = 1'b0;
        for (int p = 0; p < 3; p++) begin
            if (pk.sample_valid && pk.irq_en[p]) begin
                v_hit_d = v_hit_d | (pk.v_mag[p] > pk.v_level);
                i_hit_d = i_hit_d | (pk.i_mag[p] > pk.i_level);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            v_hit_q <= 1'b0;
            i_hit_q <= 1'b0;
        end else begin
            v_hit_q <= v_hit_d;
            i_hit_q <= i_hit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    vhit_cause_a: assert property (pk.sample_valid && pk.irq_en[2] && pk.v_mag[2] > pk.v_level |=> v_hit_q)
        else $error("phase C voltage crossing missed");
    ihit_only_a: assert property (i_hit_q |-> $past(pk.sample_valid) && $past(|pk.irq_en))
        else $error("current hit without monitored sample");
    no_hit_a: assert property (pk.irq_en == 3'b000 |=> !v_hit_q && !i_hit_q)
        else $error("hit raised with monitoring off");
endmodule

// File: rtl/pmmc_top.sv
`timescale 1ns/1ps
module pmmc_top
    import pmmc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // per-phase samples, two's complement
    input wire logic sample_valid,
    input wire logic [2:0][23:0] v_sample,
    input wire logic [2:0][23:0] i_sample,
    input wire logic [2:0] zero_cross,
    // period measurement feed
    output logic [23:0] line_freq_voltage,
    output logic line_freq_zero_cross,
    // interrupt
    output logic irq
);
    pmmc_peak_if pk_if ();

    logic [7:0] measurement_config_q, measurement_config_d;
    logic [15:0] half_cycle_count_q, half_cycle_count_d;
    logic [23:0] vlvl_q, vlvl_d, ilvl_q, ilvl_d;
    logic [2:0] status_q, status_d, mask_q, mask_d;
    logic [15:0] hc_cnt_q, hc_cnt_d;
    logic intv_end_q, intv_end_d;
    logic [23:0] lfv_q, lfv_d;
    logic lfz_q, lfz_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
    logic [23:0] voltage_peak_value, current_peak_value;
    logic v_hit, i_hit;
    logic setup, done, wr_done, rd_done;
    pmmc_rsel_e rsel;
    pmmc_fsel_e line_freq_source_sel;
    logic [2:0] peak_phase_enable, peak_irq_phase_enable;

    ////////////////////////////////////////////////////////////////////////////
    // configuration fields
    assign line_freq_source_sel = pmmc_fsel_e'(measurement_config_q[FSEL_LSB +: 2]);
    assign peak_phase_enable = measurement_config_q[PKEN_LSB +: 3];
    assign peak_irq_phase_enable = measurement_config_q[PKIRQ_LSB +: 3];

    // magnitudes feed both the tracker and the monitor
    generate
        for (genvar g = 0; g < 3; g++) begin : g_mag
            assign pk_if.v_mag[g] = pmmc_abs(v_sample[g]);
            assign pk_if.i_mag[g] = pmmc_abs(i_sample[g]);
        end
    endgenerate
    assign pk_if.sample_valid = sample_valid;
    assign pk_if.peak_en = peak_phase_enable;
    assign pk_if.irq_en = peak_irq_phase_enable;
    assign pk_if.v_level = vlvl_q;
    assign pk_if.i_level = ilvl_q;
    assign pk_if.interval_end = intv_end_q;

    pmmc_peak_tracker u_tracker (
        .pclk(pclk),
        .presetn(presetn),
        .pk(pk_if.sink),
        .voltage_peak_value_q(voltage_peak_value),
        .current_peak_value_q(current_peak_value)
    );

    pmmc_thresh_mon u_mon (
        .pclk(pclk),
        .presetn(presetn),
        .pk(pk_if.sink),
        .v_hit_q(v_hit),
        .i_hit_q(i_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // period source and half-cycle interval
    always_comb begin
        lfv_d = 24'h000000;
        lfz_d = 1'b0;
        unique case (line_freq_source_sel)
            FSEL_A: begin
                lfv_d = v_sample[0];
                lfz_d = zero_cross[0];
            end
            FSEL_B: begin
                lfv_d = v_sample[1];
                lfz_d = zero_cross[1];
            end
            FSEL_C: begin
                lfv_d = v_sample[2];
                lfz_d = zero_cross[2];
            end
            FSEL_RSVD: begin
                lfv_d = 24'h000000;
                lfz_d = 1'b0;
            end
        endcase
        hc_cnt_d = hc_cnt_q;
        intv_end_d = 1'b0;
        // count half cycles of the source phase
        if (lfz_q && half_cycle_count_q != 16'h0000) begin
            if (hc_cnt_q + 16'h0001 >= half_cycle_count_q) begin
                hc_cnt_d = 16'h0000;
                intv_end_d = 1'b1;
            end else begin
                hc_cnt_d = hc_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfv_q <= 24'h000000;
            lfz_q <= 1'b0;
            hc_cnt_q <= 16'h0000;
            intv_end_q <= 1'b0;
        end else begin
            lfv_q <= lfv_d;
            lfz_q <= lfz_d;
            hc_cnt_q <= hc_cnt_d;
            intv_end_q <= intv_end_d;
        end
    end

    assign line_freq_voltage = lfv_q;
    assign line_freq_zero_cross = lfz_q;

    ////////////////////////////////////////////////////////////////////////////
    // apb: pready rises one cycle after setup, so every transfer has one wait-free access
    assign setup = psel && !penable;
    assign done = psel && penable && pready_q;
    assign wr_done = done && pwrite;
    assign rd_done = done && !pwrite;
    assign rsel = pmmc_decode(paddr);

    always_comb begin
        pready_d = setup;
        pslverr_d = setup && rsel == RS_NONE;
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = 32'h00000000;
            if (!pwrite) begin
                unique case (rsel)
                    RS_CFG: prdata_d[7:0] = measurement_config_q;
                    RS_HCYC: prdata_d[15:0] = half_cycle_count_q;
                    RS_VLVL: prdata_d[23:0] = vlvl_q;
                    RS_ILVL: prdata_d[23:0] = ilvl_q;
                    RS_VPK: prdata_d[23:0] = voltage_peak_value;
                    RS_IPK: prdata_d[23:0] = current_peak_value;
                    RS_STAT: prdata_d[2:0] = status_q;
                    RS_MASK: prdata_d[2:0] = mask_q;
                    default: prdata_d = 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers, status and interrupt
    always_comb begin
        measurement_config_d = measurement_config_q;
        half_cycle_count_d = half_cycle_count_q;
        vlvl_d = vlvl_q;
        ilvl_d = ilvl_q;
        mask_d = mask_q;
        if (wr_done) begin
            unique case (rsel)
                RS_CFG: measurement_config_d = pwdata[7:0];
                RS_HCYC: half_cycle_count_d = pwdata[15:0];
                RS_VLVL: vlvl_d = pwdata[23:0];
                RS_ILVL: ilvl_d = pwdata[23:0];
                RS_MASK: mask_d = pwdata[2:0];
                default: mask_d = mask_q;
            endcase
        end
        status_d = status_q;
        // cleared only by a status read
        if (rd_done && rsel == RS_STAT) begin
            status_d = 3'h0;
        end
        // new events win over the clear
        status_d[ST_VPK] = status_d[ST_VPK] | v_hit;
        status_d[ST_IPK] = status_d[ST_IPK] | i_hit;
        status_d[ST_INTV] = status_d[ST_INTV] | intv_end_q;
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            measurement_config_q <= MEAS_CFG_RST;
            half_cycle_count_q <= HALF_CYC_RST;
            vlvl_q <= LVL_RST;
            ilvl_q <= LVL_RST;
            mask_q <= MASK_RST;
            status_q <= 3'h0;
            irq_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            measurement_config_q <= measurement_config_d;
            half_cycle_count_q <= half_cycle_count_d;
            vlvl_q <= vlvl_d;
            ilvl_q <= ilvl_d;
            mask_q <= mask_d;
            status_q <= status_d;
            irq_q <= irq_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    freq_route_a: assert property (line_freq_source_sel == FSEL_B |=> lfv_q == $past(v_sample[1]))
        else $error("phase B voltage not routed to period feed");
    freq_rsvd_a: assert property (line_freq_source_sel == FSEL_RSVD |=> lfz_q == 1'b0)
        else $error("reserved source produced a crossing");
    cfg_reset_a: assert property (!$past(presetn) |-> measurement_config_q == MEAS_CFG_RST)
        else $error("configuration not at reset value");
    irqsel_reset_a: assert property (!$past(presetn) |-> peak_irq_phase_enable == 3'b111)
        else $error("interrupt phase enables not all ones after reset");
    vstatus_set_a: assert property (v_hit |=> status_q[ST_VPK] && $past(status_q[ST_VPK]) == 1'b0 || status_q[ST_VPK])
        else $error("voltage crossing not recorded");
    status_sticky_a: assert property (status_q[ST_IPK] && !(rd_done && rsel == RS_STAT) |=> status_q[ST_IPK])
        else $error("current status bit dropped without a read");
    interval_len_a: assert property (intv_end_q |-> hc_cnt_q == 16'h0000 && $past(half_cycle_count_q) != 16'h0000)
        else $error("interval end with disabled or unreset count");
    irq_level_a: assert property (##1 irq_q == |(status_q & mask_q))
        else $error("interrupt output disagrees with masked status");
    apb_answer_a: assert property (setup ##1 psel && penable |-> pready_q)
        else $error("apb access not answered in one cycle");
    cfg_write_a: assert property (wr_done && rsel == RS_CFG |=> measurement_config_q == $past(pwdata[7:0]))
        else $error("configuration write not applied");
    hcyc_write_a: assert property (wr_done && rsel == RS_HCYC |=> half_cycle_count_q == $past(pwdata[15:0]))
        else $error("half-cycle count write not applied");
    vlvl_write_a: assert property (wr_done && rsel == RS_VLVL |=> vlvl_q == $past(pwdata[23:0]))
        else $error("voltage level write not applied");
    ilvl_write_a: assert property (wr_done && rsel == RS_ILVL |=> ilvl_q == $past(pwdata[23:0]))
        else $error("current level write not applied");
    mask_write_a: assert property (wr_done && rsel == RS_MASK |=> mask_q == $past(pwdata[2:0]))
        else $error("mask write not applied");
    cfg_readback_a: assert property (setup && !pwrite && rsel == RS_CFG
        |=> prdata_q == {24'h000000, $past(measurement_config_q)})
        else $error("configuration read data wrong");
    unmapped_err_a: assert property (setup && rsel == RS_NONE |=> pslverr_q && pready_q)
        else $error("unmapped address not flagged");
    pready_pulse_a: assert property (pready_q |=> !pready_q)
        else $error("pready held longer than one cycle");
    stat_clear_a: assert property (rd_done && rsel == RS_STAT
        && !v_hit && !i_hit && !intv_end_q |=> status_q == 3'h0)
        else $error("status not cleared by its read");
    istatus_set_a: assert property (i_hit |=> status_q[ST_IPK])
        else $error("current crossing not recorded");
    intv_status_a: assert property (intv_end_q |=> status_q[ST_INTV])
        else $error("interval end not recorded");
    vstatus_sticky_a: assert property (status_q[ST_VPK] && !(rd_done && rsel == RS_STAT) |=> status_q[ST_VPK])
        else $error("voltage status bit dropped without a read");
    irq_masked_a: assert property (mask_q == 3'h0 |-> !irq_q)
        else $error("interrupt raised with every source masked");
    pken_reset_a: assert property (!$past(presetn) |-> peak_phase_enable == 3'h7)
        else $error("peak phase enables not all ones after reset");
    freq_first_a: assert property (line_freq_source_sel == FSEL_A
        |=> lfv_q == $past(v_sample[0]) && lfz_q == $past(zero_cross[0]))
        else $error("phase A not routed to period feed");
    freq_third_a: assert property (line_freq_source_sel == FSEL_C
        |=> lfv_q == $past(v_sample[2]) && lfz_q == $past(zero_cross[2]))
        else $error("phase C not routed to period feed");
    freq_rsvd_zero_a: assert property (line_freq_source_sel == FSEL_RSVD |=> lfv_q == 24'h000000)
        else $error("reserved source produced a voltage");
    interval_off_a: assert property (lfz_q && half_cycle_count_q == 16'h0000 |=> !intv_end_q)
        else $error("interval ended with a zero count");
endmodule

// File: verif/test_peak_measurement_mode_control.sv
`timescale 1ns/1ps
module test_peak_measurement_mode_control;
    import pmmc_pkg::*;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sample_valid;
    logic [2:0][23:0] v_sample;
    logic [2:0][23:0] i_sample;
    logic [2:0] zero_cross;
    logic [23:0] lf_v;
    logic lf_zc;
    logic irq;
    logic [32:0] exp_q[$];
    logic [32:0] exp_now;
    logic [15:0] lfsr_q;
    logic [2:0][23:0] vv;
    logic [2:0] zc;
    logic [23:0] rz;
    int errors;
    int comparisons;

    pmmc_top u_pmmc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .v_sample(v_sample), .i_sample(i_sample),
        .zero_cross(zero_cross), .line_freq_voltage(lf_v), .line_freq_zero_cross(lf_zc), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // sixteen-bit shift register, two steps give one 24-bit value
    function automatic logic [23:0] rnd24();
        logic [15:0] a;
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        a = lfsr_q;
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return {a[7:0], lfsr_q};
    endfunction

    // e holds {pslverr, prdata}; prdata is ignored on writes
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic samp(input logic [2:0][23:0] v, input logic [2:0][23:0] i);
        @(posedge pclk);
        v_sample <= v;
        i_sample <= i;
        sample_valid <= 1'b1;
        @(posedge pclk);
        sample_valid <= 1'b0;
    endtask

    task automatic xing(input logic [2:0] z);
        @(posedge pclk);
        zero_cross <= z;
        @(posedge pclk);
        zero_cross <= 3'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // the oldest note is matched against the edge that completes a transfer
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, prdata, 32'h0);
            end else begin
                exp_now = exp_q.pop_front();
                if (pwrite === 1'b1) begin
                    check({pslverr, 32'h0}, {exp_now[32], 32'h0});
                end else begin
                    check({pslverr, prdata}, exp_now);
                end
            end
        end
    end

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        repeat (4000) @(posedge pclk);
        errors++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        lfsr_q = 16'ha17c;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sample_valid = 1'b0;
        v_sample = '0;
        i_sample = '0;
        zero_cross = 3'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_MEAS_CFG, 32'hfc);
        rd(ADDR_HALF_CYC, 32'h64);
        rd(ADDR_VLVL, 32'hffffff);
        rd(ADDR_MASK, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
        // monitoring limited to chosen phases
        wr(ADDR_VLVL, 32'h3);
        wr(ADDR_ILVL, 32'h3e8);
        wr(ADDR_MASK, 32'h3);
        wr(ADDR_MEAS_CFG, 32'h3c);
        samp({24'h0, 24'hffffce, 24'h0}, {24'h0, 24'hfff000, 24'h0});
        repeat (3) @(posedge pclk);
        rd(ADDR_STATUS, 32'h0);
        samp({24'h0, 24'h0, 24'hfffffb}, {24'h0, 24'h0, 24'h000002});
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        check({32'h0, irq}, 33'h1);
        rd(ADDR_STATUS, 32'h1);
        rd(ADDR_STATUS, 32'h0);
        @(negedge pclk);
        check({32'h0, irq}, 33'h0);
        wr(ADDR_MEAS_CFG, 32'hdc);
        wr(ADDR_MASK, 32'h0);
        samp({24'h0, 24'h0, 24'h000003}, {24'hfff830, 24'h0, 24'h0});
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check({32'h0, irq}, 33'h0);
        rd(ADDR_STATUS, 32'h2);
        // peaks over a two crossing interval, phases a and c only
        wr(ADDR_HALF_CYC, 32'h2);
        wr(ADDR_MEAS_CFG, 32'h14);
        rd(ADDR_MEAS_CFG, 32'h14);
        xing(3'h1);
        xing(3'h1);
        repeat (5) @(posedge pclk);
        rd(ADDR_STATUS, 32'h4);
        samp({24'h000032, 24'h000384, 24'hffff9c}, {24'hffffba, 24'h000384, 24'h000005});
        samp({24'hffffe2, 24'h0, 24'h000014}, {24'h00003c, 24'h0, 24'hfffffd});
        xing(3'h2);
        xing(3'h1);
        xing(3'h1);
        repeat (5) @(posedge pclk);
        rd(ADDR_VOLTAGE_PEAK_VALUE, 32'h64);
        rd(ADDR_CURRENT_PEAK_VALUE, 32'h46);
        rd(ADDR_STATUS, 32'h4);
        xing(3'h1);
        xing(3'h1);
        repeat (5) @(posedge pclk);
        rd(ADDR_VOLTAGE_PEAK_VALUE, 32'h0);
        rd(ADDR_CURRENT_PEAK_VALUE, 32'h0);
        // source routing with random samples, code 11 gives zeros
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_MEAS_CFG, {24'h0, 6'h07, k[1:0]});
            vv = {rnd24(), rnd24(), rnd24()};
            rz = rnd24();
            zc = rz[2:0];
            @(posedge pclk);
            v_sample <= vv;
            zero_cross <= zc;
            @(posedge pclk);
            zero_cross <= 3'h0;
            @(negedge pclk);
            check({9'h0, lf_v}, (k < 3) ? {9'h0, vv[k]} : 33'h0);
            check({32'h0, lf_zc}, (k < 3) ? {32'h0, zc[k]} : 33'h0);
        end
        repeat (2) @(posedge pclk);
        wrap_up();
    end
endmodule
